// ---- rtl/drsrc_top.sv ----
// Run-command qualification, fault restart and ramp timing for a motor drive.
//
// Behaviour
// - Direction lock code 0 free, 1 blocks forward, 2 blocks reverse.
// - A run in a blocked direction ramps to 0 Hz and stops without tripping.
// - Power-up start only when the command source is terminal code 1 or 2.
// - Power-up autorun on starts at once if the terminal run is already active.
// - Autorun off ignores a run held at power-up until it drops and returns.
// - Speed option bit 4 requests a speed search on a power-up autorun start.
// - Without speed search the drive starts from zero and follows the ramp.
// - A fault trip cuts the output at once and lets the motor coast.
// - Fault-clear restart on with terminal control resumes from the active run.
// - Retry limit 0 to 10, default 0; retry wait default 1.0 s.
// - Speed option bit 2 requests a speed search on a restart after reset.
// - Fault-clear restart off ignores a held run until it drops and returns.
// - Ramp basis 0: acceleration time spans 0 Hz to maximum, scaled linearly.
// - Ramp basis 0: deceleration time spans maximum frequency down to 0 Hz.
// - Ramp basis 1: times span present frequency to the new target.
// - Maximum frequency 40.00 to 400.00 Hz, default 60.00; times up to 600.0 s (time registers take any 16-bit count, unclamped).
// - Time unit code 0, 1, 2 means 0.01 s, 0.1 s, 1 s per count.
// - A unit change reinterprets stored counts in the new unit.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
module drsrc_top
   import drsrc_pkg::*;
#(
   parameter int TICK_CYC = BASE_TICK_CYC
)
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Avalon-MM register slave.
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Terminal pins: forward/reverse or run/direction.
   input  wire logic        term_a,
   input  wire logic        term_b,
   // Fault and speed search handshake from the drive core.
   input  wire logic        fault_trip,
   input  wire logic        search_done,
   input  wire logic [15:0] search_freq,
   // Drive outputs.
   output logic      [15:0] out_freq,
   output logic             out_enable,
   output logic             out_reverse,
   output logic             search_req
);
   drsrc_state_t state_ff;
   logic [31:0] cfg_ff;
   logic [15:0] delay_ff, acc_ff, dec_ff, maxf_ff, tgt_ff;
   logic        go_ff, frst_ff, need_cycle_ff, prohibit_ff;
   logic [3:0]  retry_ff;
   logic [15:0] wait_cnt_ff;
   logic [16:0] tick_cnt_ff;
   logic [6:0]  unit_cnt_ff;
   logic        unit_tick_ff;
   logic [23:0] facc_ff;
   logic [15:0] base_ff, tgt_prev_ff;
   logic [1:0]  term_s;
   logic [31:0] wmask, nxt_cfg;
   logic [23:0] step_q;
   logic        step_done;
   logic        wr_en, terminal, run_cmd, rev_cmd, dir_bad, start_ok, fault_hit;
   logic        at_zero, rising;
   logic [15:0] freq_q, tgt_eff, span, ramp_time;
   logic [6:0]  unit_len;

   drsrc_sync drsrc_sync_inst (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .pin_in    ({term_b, term_a}),
      .level_out (term_s)
   );

   // Terminal decode, direction lock and start qualification.
   assign terminal  = (cfg_ff[CFG_SRC+:3] == SRC_FWDREV) || (cfg_ff[CFG_SRC+:3] == SRC_RUNDIR);
   assign run_cmd   = (cfg_ff[CFG_SRC+:3] == SRC_FWDREV) ? (term_s[0] ^ term_s[1]) : term_s[0];
   assign rev_cmd   = (cfg_ff[CFG_SRC+:3] == SRC_FWDREV) ? term_s[1] : term_s[1];
   assign dir_bad   = ((cfg_ff[CFG_LOCK+:2] == LOCK_FWD) && !rev_cmd)
                   || ((cfg_ff[CFG_LOCK+:2] == LOCK_REV) && rev_cmd);
   assign start_ok  = terminal && run_cmd && !need_cycle_ff;
   assign fault_hit = fault_trip && (state_ff != ST_INIT) && (state_ff != ST_FAULT) && (state_ff != ST_WAIT);
   assign freq_q    = facc_ff[23:FRAC];
   assign at_zero   = (freq_q == 16'h0000);
   assign wr_en     = avs_write && !avs_waitrequest;
   assign wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign nxt_cfg   = (cfg_ff & ~wmask) | (avs_writedata & wmask);

   // Bus answer: waitrequest drops one cycle after a request is seen, then rises again.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest)
         begin
            case (avs_address)
               A_CFG:   avs_readdata <= cfg_ff;
               A_DELAY: avs_readdata <= {16'h0000, delay_ff};
               A_ACC:   avs_readdata <= {16'h0000, acc_ff};
               A_DEC:   avs_readdata <= {16'h0000, dec_ff};
               A_MAXF:  avs_readdata <= {16'h0000, maxf_ff};
               A_TGT:   avs_readdata <= {16'h0000, tgt_ff};
               A_STAT:  avs_readdata <= {4'h0, prohibit_ff, need_cycle_ff, search_req, out_reverse,
                                         retry_ff, 1'b0, state_ff, freq_q};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Register writes; limits clamp to their documented ranges.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cfg_ff   <= CFG_RST_VAL;
         delay_ff <= DELAY_RST_VAL;
         acc_ff   <= ACC_RST_VAL;
         dec_ff   <= DEC_RST_VAL;
         maxf_ff  <= MAXF_RST_VAL;
         tgt_ff   <= 16'h0000;
         go_ff    <= 1'b0;
         frst_ff  <= 1'b0;
      end
      else
      begin
         frst_ff <= wr_en && (avs_address == A_CMD) && avs_writedata[CMD_FRST];
         if (wr_en && (avs_address == A_CMD) && avs_writedata[CMD_GO])
            go_ff <= 1'b1;
         if (wr_en)
         begin
            case (avs_address)
               A_CFG:
               begin
                  cfg_ff <= nxt_cfg;
                  if (nxt_cfg[CFG_RETRY+:4] > RETRY_MAX)
                     cfg_ff[CFG_RETRY+:4] <= RETRY_MAX;
               end
               A_DELAY: delay_ff <= avs_writedata[15:0];
               A_ACC:   acc_ff   <= avs_writedata[15:0];
               A_DEC:   dec_ff   <= avs_writedata[15:0];
               A_MAXF:
                  if (avs_writedata[15:0] < MAXF_MIN)
                     maxf_ff <= MAXF_MIN;
                  else if (avs_writedata[15:0] > MAXF_MAX)
                     maxf_ff <= MAXF_MAX;
                  else
                     maxf_ff <= avs_writedata[15:0];
               A_TGT:   tgt_ff   <= avs_writedata[15:0];
               default: ;
            endcase
         end
      end
   end

   // Time unit tick: base tick every 0.01 s, prescaled by the unit code.
   assign unit_len = (cfg_ff[CFG_TS+:2] == TS_10MS)  ? 7'h01 :
                     (cfg_ff[CFG_TS+:2] == TS_100MS) ? UNIT1_TICKS : UNIT2_TICKS;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tick_cnt_ff  <= 17'h0_0000;
         unit_cnt_ff  <= 7'h00;
         unit_tick_ff <= 1'b0;
      end
      else
      begin
         unit_tick_ff <= 1'b0;
         if (tick_cnt_ff >= 17'(TICK_CYC - 1))
         begin
            tick_cnt_ff <= 17'h0_0000;
            if (unit_cnt_ff >= unit_len - 7'h01)
            begin
               unit_cnt_ff  <= 7'h00;
               unit_tick_ff <= 1'b1;
            end
            else
               unit_cnt_ff <= unit_cnt_ff + 7'h01;
         end
         else
            tick_cnt_ff <= tick_cnt_ff + 17'h0_0001;
      end
   end

   // Ramp target, direction of travel and reference span.
   assign tgt_eff   = (state_ff != ST_RUN) ? 16'h0000 : (tgt_ff > maxf_ff) ? maxf_ff : tgt_ff;
   assign rising    = tgt_eff > freq_q;
   assign ramp_time = rising ? acc_ff : dec_ff;
   assign span      = !cfg_ff[CFG_BASIS] ? maxf_ff
                    : (tgt_eff > base_ff) ? tgt_eff - base_ff : base_ff - tgt_eff;

   drsrc_div drsrc_div_inst (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .start    (unit_tick_ff),
      .dividend ({span, 8'h00}),
      .divisor  (ramp_time),
      .quotient (step_q),
      .done     (step_done)
   );

   // Frequency accumulator: cut on a fault, catch on search, else step toward the target.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         facc_ff     <= 24'h00_0000;
         base_ff     <= 16'h0000;
         tgt_prev_ff <= 16'h0000;
      end
      else
      begin
         tgt_prev_ff <= tgt_eff;
         if (tgt_eff != tgt_prev_ff)
            base_ff <= freq_q;
         if (fault_hit)
            facc_ff <= 24'h00_0000;
         else if (state_ff == ST_SEARCH && search_done)
            facc_ff <= {search_freq, 8'h00};
         else if (step_done && (state_ff == ST_RUN || state_ff == ST_STOP))
         begin
            if (ramp_time == 16'h0000)
               facc_ff <= {tgt_eff, 8'h00};
            else if (rising)
               facc_ff <= (facc_ff + step_q >= {tgt_eff, 8'h00} || facc_ff + step_q < facc_ff)
                          ? {tgt_eff, 8'h00} : facc_ff + step_q;
            else
               facc_ff <= (facc_ff - {tgt_eff, 8'h00} <= step_q)
                          ? {tgt_eff, 8'h00} : facc_ff - step_q;
         end
      end
   end

   // Output frequency register, forced to zero in the trip cycle.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         out_freq <= 16'h0000;
      else if (fault_hit)
         out_freq <= 16'h0000;
      else
         out_freq <= freq_q;
   end

   // Run state machine: power-up decision, start, stop, fault and retries.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_ff      <= ST_INIT;
         out_enable    <= 1'b0;
         out_reverse   <= 1'b0;
         search_req    <= 1'b0;
         need_cycle_ff <= 1'b1;
         prohibit_ff   <= 1'b0;
         retry_ff      <= 4'h0;
         wait_cnt_ff   <= 16'h0000;
      end
      else if (fault_hit)
      begin
         state_ff   <= ST_FAULT;
         out_enable <= 1'b0;
         search_req <= 1'b0;
      end
      else
      begin
         if (!run_cmd)
            need_cycle_ff <= 1'b0;
         case (state_ff)
            ST_INIT:
               if (go_ff)
               begin
                  if (!cfg_ff[CFG_PWR])
                     need_cycle_ff <= 1'b1;
                  if (cfg_ff[CFG_PWR] && terminal && run_cmd && !dir_bad)
                  begin
                     state_ff    <= cfg_ff[CFG_SS+SS_POWERON] ? ST_SEARCH : ST_RUN;
                     search_req  <= cfg_ff[CFG_SS+SS_POWERON];
                     out_enable  <= 1'b1;
                     out_reverse <= rev_cmd;
                  end
                  else
                  begin
                     state_ff    <= ST_IDLE;
                     prohibit_ff <= terminal && run_cmd && dir_bad;
                  end
               end
            ST_IDLE:
            begin
               prohibit_ff <= start_ok && dir_bad;
               if (start_ok && !dir_bad)
               begin
                  state_ff    <= ST_RUN;
                  out_enable  <= 1'b1;
                  out_reverse <= rev_cmd;
               end
            end
            ST_SEARCH:
               if (search_done)
               begin
                  state_ff   <= ST_RUN;
                  search_req <= 1'b0;
               end
            ST_RUN:
               if (!terminal || !run_cmd || dir_bad || (rev_cmd != out_reverse))
               begin
                  state_ff    <= ST_STOP;
                  prohibit_ff <= run_cmd && dir_bad;
               end
            ST_STOP:
               if (at_zero)
               begin
                  state_ff   <= ST_IDLE;
                  out_enable <= 1'b0;
               end
            ST_FAULT:
               if (frst_ff || (retry_ff < cfg_ff[CFG_RETRY+:4]))
               begin
                  state_ff    <= frst_ff ? ST_WAIT : ST_WAIT;
                  wait_cnt_ff <= frst_ff ? 16'h0000 : delay_ff;
                  if (frst_ff)
                     retry_ff <= 4'h0;
               end
            ST_WAIT:
               if (unit_tick_ff && (wait_cnt_ff != 16'h0000))
                  wait_cnt_ff <= wait_cnt_ff - 16'h0001;
               else if (wait_cnt_ff == 16'h0000)
               begin
                  if (retry_ff < cfg_ff[CFG_RETRY+:4] && !frst_ff)
                     retry_ff <= retry_ff + 4'h1;
                  if (cfg_ff[CFG_RST] && terminal && run_cmd && !dir_bad)
                  begin
                     state_ff    <= cfg_ff[CFG_SS+SS_RESTART] ? ST_SEARCH : ST_RUN;
                     search_req  <= cfg_ff[CFG_SS+SS_RESTART];
                     out_enable  <= 1'b1;
                     out_reverse <= rev_cmd;
                  end
                  else
                  begin
                     state_ff <= ST_IDLE;
                     if (!cfg_ff[CFG_RST])
                        need_cycle_ff <= 1'b1;
                  end
               end
            default:
               state_ff <= ST_INIT;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_fault_cut;
      fault_hit |=> !out_enable && (out_freq == 16'h0000) && (state_ff == ST_FAULT);
   endproperty
   a_fault_cut: assert property (p_fault_cut) else $error("Output not cut on fault.");

   property p_lock_stop;
      (state_ff == ST_RUN) && dir_bad && !fault_hit |=> (state_ff == ST_STOP) && out_enable;
   endproperty
   a_lock_stop: assert property (p_lock_stop) else $error("Blocked direction did not ramp down.");

   property p_lock_hold;
      (state_ff == ST_IDLE) && start_ok && dir_bad && !fault_hit |=> (state_ff == ST_IDLE) && !out_enable;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("Blocked direction started.");

   property p_src;
      (state_ff == ST_INIT) && go_ff && !terminal |=> (state_ff == ST_IDLE) && !out_enable;
   endproperty
   a_src: assert property (p_src) else $error("Power-up start without terminal source.");

   property p_autorun;
      (state_ff == ST_INIT) && go_ff && cfg_ff[CFG_PWR] && terminal && run_cmd && !dir_bad && !fault_hit
         |=> out_enable && (search_req == $past(cfg_ff[CFG_SS+SS_POWERON]));
   endproperty
   a_autorun: assert property (p_autorun) else $error("Power-up autorun missed.");

   property p_no_autorun;
      (state_ff == ST_INIT) && go_ff && !cfg_ff[CFG_PWR] && !fault_hit |=> need_cycle_ff && !out_enable;
   endproperty
   a_no_autorun: assert property (p_no_autorun) else $error("Held run accepted at power-up.");

   property p_retry_wait;
      (state_ff == ST_FAULT) && !frst_ff && (retry_ff < cfg_ff[CFG_RETRY+:4]) && !fault_trip
         |=> (state_ff == ST_WAIT) && (wait_cnt_ff == $past(delay_ff));
   endproperty
   a_retry_wait: assert property (p_retry_wait) else $error("Retry wait not loaded.");

   property p_retry_limit;
      (state_ff == ST_FAULT) && !frst_ff && (retry_ff >= cfg_ff[CFG_RETRY+:4]) |=> (state_ff == ST_FAULT);
   endproperty
   a_retry_limit: assert property (p_retry_limit) else $error("Retry beyond the limit.");

   property p_ramp_up;
      (state_ff == ST_RUN) && !fault_hit && (freq_q < tgt_eff) |=> freq_q >= $past(freq_q);
   endproperty
   a_ramp_up: assert property (p_ramp_up) else $error("Frequency fell while accelerating.");
endmodule

// ---- rtl/drsrc_pkg.sv ----
// Shared constants and types for the run-start and ramp control block.
package drsrc_pkg;
   // Clock rate and the base ramp tick of 0.01 s.
   localparam int CLK_HZ         = 10_000_000;
   localparam int BASE_TICK_MS   = 10;
   localparam int BASE_TICK_CYC  = CLK_HZ / 1000 * BASE_TICK_MS;
   // Base ticks per time unit for the 0.1 s and 1 s codes.
   localparam logic [6:0] UNIT1_TICKS = 7'h0A;
   localparam logic [6:0] UNIT2_TICKS = 7'h64;
   // Register byte offsets.
   localparam logic [4:0] A_CFG   = 5'h00;
   localparam logic [4:0] A_DELAY = 5'h04;
   localparam logic [4:0] A_ACC   = 5'h08;
   localparam logic [4:0] A_DEC   = 5'h0C;
   localparam logic [4:0] A_MAXF  = 5'h10;
   localparam logic [4:0] A_TGT   = 5'h14;
   localparam logic [4:0] A_CMD   = 5'h18;
   localparam logic [4:0] A_STAT  = 5'h1C;
   // Configuration field positions.
   localparam int CFG_SRC   = 0;
   localparam int CFG_LOCK  = 4;
   localparam int CFG_PWR   = 6;
   localparam int CFG_RST   = 7;
   localparam int CFG_BASIS = 8;
   localparam int CFG_TS    = 10;
   localparam int CFG_RETRY = 12;
   localparam int CFG_SS    = 16;
   localparam int SS_RESTART = 2;
   localparam int SS_POWERON = 4;
   localparam int CMD_GO    = 0;
   localparam int CMD_FRST  = 1;
   // Codes of the configuration fields.
   localparam logic [2:0] SRC_FWDREV = 3'h1;
   localparam logic [2:0] SRC_RUNDIR = 3'h2;
   localparam logic [1:0] LOCK_FWD   = 2'h1;
   localparam logic [1:0] LOCK_REV   = 2'h2;
   localparam logic [1:0] TS_10MS    = 2'h0;
   localparam logic [1:0] TS_100MS   = 2'h1;
   localparam logic [3:0] RETRY_MAX  = 4'hA;
   // Reset values; frequencies in 0.01 Hz, times in counts of the unit.
   localparam logic [31:0] CFG_RST_VAL   = 32'h0000_0401;
   localparam logic [15:0] DELAY_RST_VAL = 16'h000A;
   localparam logic [15:0] ACC_RST_VAL   = 16'h00C8;
   localparam logic [15:0] DEC_RST_VAL   = 16'h012C;
   localparam logic [15:0] MAXF_RST_VAL  = 16'h1770;
   localparam logic [15:0] MAXF_MIN      = 16'h0FA0;
   localparam logic [15:0] MAXF_MAX      = 16'h9C40;
   localparam int FRAC = 8;
   // Drive states, Gray coded along init, idle, search, run, stop.
   typedef enum logic [2:0] {
      ST_INIT   = 3'h0,
      ST_IDLE   = 3'h1,
      ST_SEARCH = 3'h3,
      ST_RUN    = 3'h2,
      ST_STOP   = 3'h6,
      ST_FAULT  = 3'h7,
      ST_WAIT   = 3'h5
   } drsrc_state_t;
endpackage

// ---- rtl/drsrc_sync.sv ----
// Three-stage synchroniser with agreement filter for the terminal pins.
`timescale 1ns/1ns
module drsrc_sync
   import drsrc_pkg::*;
(
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Raw pins and filtered levels.
   input  wire logic [1:0] pin_in,
   output logic      [1:0] level_out
);
   logic [1:0] s1_ff;
   logic [1:0] s2_ff;
   logic [1:0] s3_ff;

   // Each pin passes three flops; the output follows once stages two and three agree.
   for (genvar i = 0; i < 2; i++)
   begin : g_bit
      always_ff @(posedge sys_clk)
      begin
         if (reset)
         begin
            s1_ff[i]     <= 1'b0;
            s2_ff[i]     <= 1'b0;
            s3_ff[i]     <= 1'b0;
            level_out[i] <= 1'b0;
         end
         else
         begin
            s1_ff[i] <= pin_in[i];
            s2_ff[i] <= s1_ff[i];
            s3_ff[i] <= s2_ff[i];
            if (s2_ff[i] == s3_ff[i])
               level_out[i] <= s3_ff[i];
         end
      end
   end
endmodule

// ---- rtl/drsrc_div.sv ----
// Sequential restoring divider that yields the ramp step per time unit.
`timescale 1ns/1ns
module drsrc_div
   import drsrc_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Operands and start strobe.
   input  wire logic        start,
   input  wire logic [23:0] dividend,
   input  wire logic [15:0] divisor,
   // Quotient and one-cycle done pulse.
   output logic      [23:0] quotient,
   output logic             done
);
   logic [16:0] rem_ff;
   logic [4:0]  cnt_ff;
   logic        busy_ff;
   logic [16:0] trial;

   // Trial subtraction of the divisor from the shifted remainder.
   assign trial = {rem_ff[15:0], quotient[23]} - {1'b0, divisor};

   // One quotient bit per cycle, 24 cycles after the start strobe.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rem_ff   <= 17'h0_0000;
         cnt_ff   <= 5'h00;
         busy_ff  <= 1'b0;
         quotient <= 24'h00_0000;
         done     <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            rem_ff   <= 17'h0_0000;
            quotient <= dividend;
            cnt_ff   <= 5'h18;
            busy_ff  <= 1'b1;
         end
         else if (busy_ff)
         begin
            if (!trial[16])
               rem_ff <= trial;
            else
               rem_ff <= {rem_ff[15:0], quotient[23]};
            quotient <= {quotient[22:0], ~trial[16]};
            cnt_ff   <= cnt_ff - 5'h01;
            if (cnt_ff == 5'h01)
            begin
               busy_ff <= 1'b0;
               done    <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- bench/drsrc_motor.sv ----
// Motor model that answers speed search requests.
`timescale 1ns/1ns
module drsrc_motor
   import drsrc_pkg::*;
(
   // Clock and search handshake.
   input  wire logic        sys_clk,
   input  wire logic        search_req,
   output logic             search_done,
   output logic      [15:0] search_freq
);
   int cnt = 0;
   // Idle values before the first edge.
   initial
   begin
      search_done = 1'b0;
      search_freq = 16'h0000;
   end
   // The coasting speed is only valid in the done cycle.
   always @(posedge sys_clk)
   begin
      cnt <= search_req ? cnt + 1 : 0;
      search_done <= (cnt == 15);
      search_freq <= (cnt == 15) ? 16'h0BB8 : ~search_freq;
   end
endmodule

// ---- bench/drsrc_top_tb.sv ----
// Self-checking bench for the run-start and ramp control block.
`timescale 1ns/1ns
module drsrc_top_tb;
   import drsrc_pkg::*;
   logic        sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        avs_waitrequest, term_a = 1'b0, term_b = 1'b0, fault_trip = 1'b0;
   logic        search_done, search_req, out_enable, out_reverse;
   logic [15:0] search_freq, out_freq;
   int          num_errors = 0, num_checks = 0, cyc = 0;
   // Clock of 100 ns.
   always #50 sys_clk = ~sys_clk;
   // Block under test and motor model.
   // The base tick must outlast the 25-cycle step division, or the ramp never moves.
   drsrc_top #(.TICK_CYC(40)) drsrc_top_inst (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .term_a(term_a), .term_b(term_b),
      .fault_trip(fault_trip), .search_done(search_done), .search_freq(search_freq), .out_freq(out_freq),
      .out_enable(out_enable), .out_reverse(out_reverse), .search_req(search_req));
   drsrc_motor drsrc_motor_inst (.sys_clk(sys_clk), .search_req(search_req), .search_done(search_done),
      .search_freq(search_freq));
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Compares a seen value with an expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Holds reset for five cycles.
   task automatic do_reset;
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
   endtask
   // Reset values and clamping of the maximum frequency.
   task automatic t_regs;
      bus(1'b0, A_CFG, 32'h0);
      check(q, CFG_RST_VAL);
      bus(1'b0, A_DELAY, 32'h0);
      check(q, DELAY_RST_VAL);
      bus(1'b1, A_MAXF, 32'h0000_0001);
      bus(1'b0, A_MAXF, 32'h0);
      check(q, MAXF_MIN);
      bus(1'b1, A_MAXF, MAXF_RST_VAL);
   endtask
   // A run held at power-up waits for a recycle, then ramps to target.
   task automatic t_hold;
      bus(1'b1, A_CFG, 32'h0000_0001);
      bus(1'b1, A_TGT, 32'h0000_0BB8);
      term_a <= 1'b1;
      bus(1'b1, A_CMD, 32'h0000_0001);
      repeat (20) @(posedge sys_clk);
      check(out_enable, 1'b0);
      term_a <= 1'b0;
      repeat (10) @(posedge sys_clk);
      term_a <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check(out_enable, 1'b1);
      repeat (4200) @(posedge sys_clk);
      check(out_freq, 16'h0BB8);
   endtask
   // A trip cuts the output; a held run is ignored after the reset.
   task automatic t_trip;
      fault_trip <= 1'b1;
      @(posedge sys_clk);
      fault_trip <= 1'b0;
      @(negedge sys_clk);
      check({out_enable, out_freq}, 17'h0);
      bus(1'b1, A_CMD, 32'h0000_0002);
      repeat (30) @(posedge sys_clk);
      check(out_enable, 1'b0);
   endtask
   // Forward is blocked, reverse still starts.
   task automatic t_lock;
      term_a <= 1'b0;
      bus(1'b1, A_CFG, 32'h0000_0011);
      repeat (10) @(posedge sys_clk);
      term_a <= 1'b1;
      repeat (20) @(posedge sys_clk);
      bus(1'b0, A_STAT, 32'h0);
      check({q[27], out_enable}, 2'h2);
      term_a <= 1'b0;
      term_b <= 1'b1;
      repeat (20) @(posedge sys_clk);
      check({out_enable, out_reverse}, 2'h3);
      // Blocking reverse while running ramps down to a stop and flags the block.
      repeat (200) @(posedge sys_clk);
      bus(1'b1, A_CFG, 32'h0000_0021);
      repeat (600) @(posedge sys_clk);
      bus(1'b0, A_STAT, 32'h0);
      check({q[27], out_enable}, 2'h2);
   endtask
   // Autorun with speed search on a run held at power-up.
   task automatic t_auto;
      term_b <= 1'b0;
      term_a <= 1'b1;
      do_reset();
      bus(1'b1, A_CFG, 32'h0010_0041);
      bus(1'b1, A_CMD, 32'h0000_0001);
      repeat (8) @(posedge sys_clk);
      check(search_req, 1'b1);
      repeat (40) @(posedge sys_clk);
      check(out_enable, 1'b1);
      bus(1'b0, A_STAT, 32'h0);
      check(q[18:16], ST_RUN);
   endtask
   // Automatic retry with search, the retry limit, then a manual reset restart.
   task automatic t_retry;
      bus(1'b1, A_CFG, 32'h0004_1081);
      bus(1'b1, A_DELAY, 32'h0000_0002);
      fault_trip <= 1'b1;
      @(posedge sys_clk);
      fault_trip <= 1'b0;
      repeat (200) @(posedge sys_clk);
      bus(1'b0, A_STAT, 32'h0);
      check({q[23:20], q[18:16], out_enable}, {4'h1, ST_RUN, 1'b1});
      check(q[15:0] > 16'h0800, 1'b1);
      fault_trip <= 1'b1;
      @(posedge sys_clk);
      fault_trip <= 1'b0;
      repeat (50) @(posedge sys_clk);
      bus(1'b0, A_STAT, 32'h0);
      check({q[18:16], out_enable}, {ST_FAULT, 1'b0});
      bus(1'b1, A_CMD, 32'h0000_0002);
      repeat (60) @(posedge sys_clk);
      check(out_enable, 1'b1);
   endtask
   // Cuts a hang short.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   // Main sequence.
   initial
   begin
      do_reset();
      t_regs();
      t_hold();
      t_trip();
      t_lock();
      t_auto();
      t_retry();
      give_verdict();
   end
endmodule
